// [program_sequencer_stack.sv]
// Program sequencer: phase generation, fetch pipeline, program counter, return stack,
// table lookup addressing and data memory decode with indirect and bit access.
// Assumes an external decoder presents the current operation on op_code during slot 4,
// and that program ROM returns rom_data combinationally on the same clock.
`timescale 1ns/1ps
`include "seq_consts.svh"
module program_sequencer_stack
  import seq_pkg::*;
#(
  parameter int PC_W = 12,
  parameter bit LARGE_RAM = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Decoded operation from the instruction decoder
  input wire op_type op_code,
  input wire logic skip_true,
  input wire logic [11:0] op_addr,
  input wire logic [7:0] op_mem_addr,
  input wire logic [2:0] op_bit,
  input wire logic [7:0] op_wdata,
  // Interrupt sources and control
  input wire logic ext_irq_n,
  input wire logic srate_ovf,
  input wire logic timer_ovf,
  input wire logic [2:0] irq_enable,
  input wire logic master_irq_enable_set,
  // Program ROM
  output logic [11:0] rom_addr,
  input wire logic [`WORD_W-1:0] rom_data,
  // Data RAM
  output logic [7:0] ram_addr,
  output logic ram_we,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  // Status towards the core
  output logic [7:0] read_data,
  output logic [`WORD_W-1:0] instr_word,
  output logic instr_valid,
  output logic [`PHASES-1:0] phase_clocks,
  output logic [2:0] irq_flags,
  output logic master_irq_enable,
  output logic [11:0] pc_out
);

  // Refuse sizes the logic cannot serve.
  initial begin
    if (PC_W != 11 && PC_W != 12) $error("PC_W must be 11 or 12");
    // The circular write index is two bits wide, so the depth is fixed at four.
    if (`STACK_LEVELS != 4) $error("stack depth must be 4");
    // A table word must carry a full low byte plus at least one upper bit.
    if (`WORD_W < 9) $error("word width too small for a table read");
  end


  phase_type phase_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] stack_mem [0:`STACK_LEVELS-1];
  logic [2:0] stack_pointer;
  logic [1:0] wr_idx;
  logic [6:0] memory_pointer;
  logic [7:0] table_pointer;
  logic [7:0] table_high_byte;
  logic dummy_reg;
  logic tbl_pend_reg;
  logic tbl_last_reg;
  logic tbl_last_sel;
  logic tbl_rom_sel;
  logic [7:0] tbl_dest_reg;
  logic [PC_W-1:0] tbl_addr;
  logic [2:0] irq_sync1;
  logic [2:0] irq_sync2;
  logic irq_prev;
  logic [2:0] irq_flag_reg;
  logic [2:0] irq_service;
  logic stack_full;
  logic slot_end;
  logic [7:0] eff_addr;
  logic [7:0] rd_mux;
  logic [7:0] bit_mask;
  logic pc_change;
  logic do_push;
  logic do_pop;
  logic ext_edge;

  // Slot 4 closes each instruction cycle; almost every state change happens there.
  assign slot_end = (phase_reg == PH4);
  assign stack_full = (stack_pointer == 3'(`STACK_LEVELS));
  // Indirect location goes through memory_pointer; bit 7 of the pointer reads as one.
  assign eff_addr = (op_mem_addr == `ADDR_INDIRECT) ? {1'b0, memory_pointer} : op_mem_addr;
  assign bit_mask = 8'h01 << op_bit;
  assign ext_edge = irq_prev & ~irq_sync2[0];


  // Fixed priority: the lowest vector wins among enabled, pending sources.
  always_comb begin
    irq_service = 3'h0;
    if (master_irq_enable && !stack_full && !dummy_reg && !tbl_pend_reg) begin
      if (irq_flag_reg[0] && irq_enable[0]) irq_service = 3'b001;
      else if (irq_flag_reg[1] && irq_enable[1]) irq_service = 3'b010;
      else if (irq_flag_reg[2] && irq_enable[2]) irq_service = 3'b100;
    end
  end

  // An acknowledge takes the slot from the operation, so the decoder must stall it.

  assign do_push = slot_end && !dummy_reg && !tbl_pend_reg &&
                   ((irq_service != 3'h0) || op_code == OP_CALL);
  assign do_pop = slot_end && !dummy_reg && !tbl_pend_reg && irq_service == 3'h0 &&
                  (op_code == OP_RET || op_code == OP_RETURN_FROM_INTERRUPT) && stack_pointer != 3'h0;
  assign pc_change = (irq_service != 3'h0) || op_code == OP_JUMP || op_code == OP_CALL ||
                     op_code == OP_RET || op_code == OP_RETURN_FROM_INTERRUPT ||
                     (op_code == OP_SKIP && skip_true) ||
                     (op_code == OP_WRITE && op_mem_addr == `ADDR_PC_LOW);

  // The operation code is gone by the second table cycle, so the page choice is kept.
  assign tbl_last_sel = tbl_pend_reg ? tbl_last_reg : (op_code == OP_TBL_LAST);
  assign tbl_addr = tbl_last_sel ? {{(PC_W-8){1'b1}}, table_pointer}
                                 : {pc_reg[PC_W-1:8], table_pointer};

  // The ROM shows the table word for the whole second cycle, up to its closing slot.
  assign tbl_rom_sel = slot_end ? ((op_code == OP_TBL_CUR || op_code == OP_TBL_LAST) &&
                                   !dummy_reg && !tbl_pend_reg)
                                : tbl_pend_reg;


  // Read decode over the data space.
  always_comb begin
    rd_mux = 8'h00;
    if (eff_addr == `ADDR_MEM_PTR) rd_mux = {1'b1, memory_pointer};
    else if (eff_addr == `ADDR_PC_LOW) rd_mux = pc_reg[7:0];
    else if (eff_addr == `ADDR_TBL_PTR) rd_mux = table_pointer;
    else if (eff_addr == `ADDR_TBL_HIGH) rd_mux = table_high_byte;
    else if (eff_addr >= `ADDR_GP_START &&
             eff_addr <= (LARGE_RAM ? `ADDR_GP_END_LARGE : `ADDR_GP_END_SMALL)) begin
      rd_mux = ram_rdata;
    end
  end


  // Phase ring: one slot per system clock.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= PH1;
    end else begin
      case (phase_reg)
        PH1: phase_reg <= PH2;
        PH2: phase_reg <= PH3;
        PH3: phase_reg <= PH4;
        PH4: phase_reg <= PH1;
        default: phase_reg <= PH1;
      endcase
    end
  end

  // Visible copy of the ring; it starts in step with the internal phase.

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) phase_clocks <= 4'h1;
    else phase_clocks <= {phase_clocks[2:0], phase_clocks[3]};
  end


  // Interrupt pins are asynchronous; the first stage feeds only the second.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_sync1 <= 3'b001;
      irq_sync2 <= 3'b001;
      irq_prev <= 1'b1;
    end else begin
      irq_sync1 <= {timer_ovf, srate_ovf, ext_irq_n};
      irq_sync2 <= irq_sync1;
      irq_prev <= irq_sync2[0];
    end
  end


  // Request flags: a new event wins over the acknowledge clear of the same cycle.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_flag_reg <= 3'h0;
    end else begin
      irq_flag_reg <= (irq_flag_reg & ~(do_push ? irq_service : 3'h0)) |
                      {irq_sync2[2], irq_sync2[1], ext_edge};
    end
  end

  // Acknowledge clears the master enable; a return from interrupt sets it again.

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) master_irq_enable <= 1'b0;
    else if (slot_end && irq_service != 3'h0) master_irq_enable <= 1'b0;
    else if (master_irq_enable_set) master_irq_enable <= 1'b1;
    else if (do_pop && op_code == OP_RETURN_FROM_INTERRUPT) master_irq_enable <= 1'b1;
  end


  // Program counter and pipeline bubble control.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pc_reg <= PC_W'(`VEC_RESET);
      dummy_reg <= 1'b0;
      tbl_pend_reg <= 1'b0;
      tbl_last_reg <= 1'b0;
    end else if (slot_end) begin
      if (dummy_reg || tbl_pend_reg) begin
        dummy_reg <= 1'b0;
        tbl_pend_reg <= 1'b0;
        if (dummy_reg) pc_reg <= pc_reg + PC_W'(1);
      end else if (irq_service[0]) begin
        pc_reg <= PC_W'(`VEC_EXT);
        dummy_reg <= 1'b1;
      end else if (irq_service[1]) begin
        pc_reg <= PC_W'(`VEC_SRATE);
        dummy_reg <= 1'b1;
      end else if (irq_service[2]) begin
        pc_reg <= PC_W'(`VEC_TIMER);
        dummy_reg <= 1'b1;
      end else begin
        case (op_code)
          OP_JUMP, OP_CALL: pc_reg <= op_addr[PC_W-1:0];
          OP_RET, OP_RETURN_FROM_INTERRUPT: pc_reg <= stack_mem[wr_idx - 2'd1];
          OP_SKIP: if (skip_true) pc_reg <= pc_reg + PC_W'(1);
          OP_WRITE: begin
            if (op_mem_addr == `ADDR_PC_LOW) pc_reg <= {pc_reg[PC_W-1:8], op_wdata};
            else pc_reg <= pc_reg + PC_W'(1);
          end
          OP_TBL_CUR, OP_TBL_LAST: begin
            tbl_pend_reg <= 1'b1;
            tbl_last_reg <= (op_code == OP_TBL_LAST);
          end
          default: pc_reg <= pc_reg + PC_W'(1);
        endcase
        if (pc_change) dummy_reg <= 1'b1;
      end
    end
  end


  // Circular stack: a push on a full stack overwrites the oldest entry.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stack_pointer <= 3'h0;
      wr_idx <= 2'h0;
      for (int i = 0; i < `STACK_LEVELS; i++) stack_mem[i] <= '0;
    end else if (do_push) begin
      stack_mem[wr_idx] <= pc_reg;
      wr_idx <= wr_idx + 2'd1;
      if (!stack_full) stack_pointer <= stack_pointer + 3'd1;
    end else if (do_pop) begin
      wr_idx <= wr_idx - 2'd1;
      stack_pointer <= stack_pointer - 3'd1;
    end
  end


  // Registers in the data space and the table fetch.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      memory_pointer <= 7'h00;
      table_pointer <= 8'h00;
      table_high_byte <= 8'h00;
      tbl_dest_reg <= 8'h00;
    end else if (slot_end && !dummy_reg) begin
      if (tbl_pend_reg) begin
        table_high_byte <= 8'(rom_data[`WORD_W-1:8]);
      end else if (op_code == OP_TBL_CUR || op_code == OP_TBL_LAST) begin
        tbl_dest_reg <= eff_addr;
      end else if (op_code == OP_WRITE || op_code == OP_BIT_SET || op_code == OP_BIT_CLR) begin
        if (eff_addr == `ADDR_MEM_PTR) begin
          case (op_code)
            OP_BIT_SET: memory_pointer <= memory_pointer | bit_mask[6:0];
            OP_BIT_CLR: memory_pointer <= memory_pointer & ~bit_mask[6:0];
            default: memory_pointer <= op_wdata[6:0];
          endcase
        end else if (eff_addr == `ADDR_TBL_PTR) begin
          case (op_code)
            OP_BIT_SET: table_pointer <= table_pointer | bit_mask;
            OP_BIT_CLR: table_pointer <= table_pointer & ~bit_mask;
            default: table_pointer <= op_wdata;
          endcase
        end
      end
    end
  end

  // Bit operations on RAM read the word at the address presented one clock earlier,
  // so the decoder must hold the data address steady into slot 4.

  // Outputs to the arrays, registered once per slot.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rom_addr <= 12'h000;
      ram_addr <= 8'h00;
      ram_we <= 1'b0;
      ram_wdata <= 8'h00;
      read_data <= 8'h00;
      instr_word <= '0;
      instr_valid <= 1'b0;
      pc_out <= 12'h000;
    end else begin
      rom_addr <= 12'(tbl_rom_sel ? tbl_addr : pc_reg);
      pc_out <= 12'(pc_reg);
      read_data <= rd_mux;
      ram_we <= 1'b0;
      instr_valid <= 1'b0;
      if (slot_end) begin
        instr_word <= rom_data;
        instr_valid <= !dummy_reg && !tbl_pend_reg;
        if (tbl_pend_reg) begin
          ram_addr <= tbl_dest_reg;
          ram_wdata <= rom_data[7:0];
          ram_we <= tbl_dest_reg >= `ADDR_GP_START;
        end else if (!dummy_reg && eff_addr >= `ADDR_GP_START &&
                     (op_code == OP_WRITE || op_code == OP_BIT_SET || op_code == OP_BIT_CLR)) begin
          ram_addr <= eff_addr;
          ram_we <= 1'b1;
          ram_wdata <= (op_code == OP_BIT_SET) ? (ram_rdata | bit_mask) :
                       (op_code == OP_BIT_CLR) ? (ram_rdata & ~bit_mask) : op_wdata;
        end
      end else begin
        ram_addr <= eff_addr;
      end
    end
  end


  assign irq_flags = irq_flag_reg;
endmodule : program_sequencer_stack

// [program_sequencer_stack_checker.sv]
// Checker for the sequencer: phase ring, PC update timing, vectors and RAM writes.
// Assumes it is bound to program_sequencer_stack and sees only that module's ports.
`timescale 1ns/1ps
module program_sequencer_stack_checker #(
  parameter int PC_W = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Observed outputs
  input wire logic [11:0] pc_out,
  input wire logic [3:0] phase_clocks,
  input wire logic [2:0] irq_flags,
  input wire logic master_irq_enable,
  input wire logic [7:0] ram_addr,
  input wire logic ram_we
);
  default clocking cb @(posedge clk_sys);
  endclocking
  property p_ring;
    disable iff (!nrst) phase_clocks == 4'h8 |=> phase_clocks == 4'h1 ##1 phase_clocks == 4'h2
      ##1 phase_clocks == 4'h4 ##1 phase_clocks == 4'h8;
  endproperty
  a_ring: assert property (p_ring) else $error("phase ring out of order");
  // The PC moves at the slot 4 edge and its copy one clock later, so a change shows in slot 2.
  property p_pc_slot;
    disable iff (!nrst) $changed(pc_out) |-> phase_clocks == 4'h2;
  endproperty
  a_pc_slot: assert property (p_pc_slot) else $error("pc moved off the slot edge");
  property p_reset;
    !nrst ##1 !nrst |-> pc_out == 12'h000 && phase_clocks == 4'h1 && !master_irq_enable;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_vec_ext;
    disable iff (!nrst) $fell(irq_flags[0]) |-> !master_irq_enable ##1 pc_out == 12'h004;
  endproperty
  a_vec_ext: assert property (p_vec_ext) else $error("external vector wrong");
  property p_vec_srate;
    disable iff (!nrst) $fell(irq_flags[1]) |-> !master_irq_enable ##1 pc_out == 12'h008;
  endproperty
  a_vec_srate: assert property (p_vec_srate) else $error("sampling vector wrong");
  property p_vec_timer;
    disable iff (!nrst) $fell(irq_flags[2]) |-> !master_irq_enable ##1 pc_out == 12'h00C;
  endproperty
  a_vec_timer: assert property (p_vec_timer) else $error("timer vector wrong");
  property p_indirect;
    disable iff (!nrst) ram_we |-> ram_addr != 8'h00 ##1 !ram_we;
  endproperty
  a_indirect: assert property (p_indirect) else $error("write reached address zero");
  property p_pc_width;
    disable iff (!nrst) PC_W == 12 || pc_out[11] == 1'b0;
  endproperty
  a_pc_width: assert property (p_pc_width) else $error("pc wider than the part");
  c_ext: cover property ($fell(irq_flags[0]));
  c_srate: cover property ($fell(irq_flags[1]));
  c_bit: cover property (ram_we && ram_addr == 8'h32);
endmodule : program_sequencer_stack_checker

bind program_sequencer_stack program_sequencer_stack_checker #(.PC_W(PC_W)) checker_i (
  .clk_sys, .nrst, .pc_out, .phase_clocks, .irq_flags, .master_irq_enable, .ram_addr, .ram_we
);

// [seq_consts.svh]
// Constants for the program sequencer and return stack: offsets, vectors, widths, timing.
// Assumes inclusion by the sequencer design module only.
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define ADDR_INDIRECT 8'h00
`define ADDR_MEM_PTR 8'h01
`define ADDR_PC_LOW 8'h06
`define ADDR_TBL_PTR 8'h07
`define ADDR_TBL_HIGH 8'h08
`define ADDR_SFR_END 8'h2F
`define ADDR_GP_START 8'h30
`define ADDR_GP_END_LARGE 8'h9F
`define ADDR_GP_END_SMALL 8'h7F
`define VEC_RESET 12'h000
`define VEC_EXT 12'h004
`define VEC_SRATE 12'h008
`define VEC_TIMER 12'h00C
`define STACK_LEVELS 4
`define PHASES 4
`define WORD_W 15
`endif

// [seq_mem_model.sv]
// Behavioural program ROM and data RAM on the far side of the sequencer.
// Assumes one clock; both arrays answer reads combinationally.
`timescale 1ns/1ps
module seq_mem_model (
  // Clock
  input wire logic clk_sys,
  // Program ROM
  input wire logic [11:0] rom_addr,
  output logic [14:0] rom_data,
  // Data RAM
  input wire logic [7:0] ram_addr,
  input wire logic ram_we,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  logic [7:0] ram [0:255];
  // Each word carries its own address, so a table result proves which word was fetched.
  assign rom_data = {3'h5, rom_addr};
  assign ram_rdata = ram[ram_addr];
  always_ff @(posedge clk_sys) begin
    if (ram_we) begin
      ram[ram_addr] <= ram_wdata;
    end
  end
endmodule : seq_mem_model

// [seq_pkg.sv]
// Types shared by the program sequencer.
// Assumes seq_consts.svh is available on the include path.
package seq_pkg;
  typedef enum logic [3:0] {
    PH1 = 4'b0001,
    PH2 = 4'b0010,
    PH3 = 4'b0100,
    PH4 = 4'b1000
  } phase_type;
  typedef enum logic [3:0] {
    OP_NEXT = 4'h0,
    OP_SKIP = 4'h1,
    OP_JUMP = 4'h2,
    OP_CALL = 4'h3,
    OP_RET = 4'h4,
    OP_RETURN_FROM_INTERRUPT = 4'h5,
    OP_TBL_CUR = 4'h6,
    OP_TBL_LAST = 4'h7,
    OP_BIT_SET = 4'h8,
    OP_BIT_CLR = 4'h9,
    OP_WRITE = 4'hA
  } op_type;
endpackage : seq_pkg

// [tb.sv]
// Self-checking bench for the sequencer with the ROM and RAM model attached.
// Assumes the checker file binds itself to the design.
`timescale 1ns/1ps
module tb;
  import seq_pkg::*;
  logic clk_sys, nrst, skip_true, ext_irq_n, srate_ovf, timer_ovf, master_irq_enable_set;
  op_type op_code;
  logic [11:0] op_addr, rom_addr, pc_out;
  logic [7:0] op_mem_addr, op_wdata, ram_addr, ram_wdata, ram_rdata, read_data;
  logic [2:0] op_bit, irq_enable, irq_flags;
  logic [14:0] rom_data;
  logic [3:0] phase_clocks;
  logic ram_we, master_irq_enable;
  int n_errors, tests_run;

  program_sequencer_stack dut (.clk_sys, .nrst, .op_code, .skip_true, .op_addr, .op_mem_addr,
    .op_bit, .op_wdata, .ext_irq_n, .srate_ovf, .timer_ovf, .irq_enable, .master_irq_enable_set,
    .rom_addr, .rom_data, .ram_addr, .ram_we, .ram_wdata, .ram_rdata, .read_data,
    .instr_word(), .instr_valid(), .phase_clocks, .irq_flags, .master_irq_enable, .pc_out);
  seq_mem_model mem (.clk_sys, .rom_addr, .rom_data, .ram_addr, .ram_we, .ram_wdata, .ram_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // Operations are only taken in slot 4, so each one waits for it and lasts one clock.
  task automatic op(input op_type c, input logic [11:0] a, input logic [7:0] m,
                    input logic [2:0] b, input logic [7:0] d);
    int i;
    i = 0;
    while (phase_clocks !== 4'h8 && i < 8) begin
      tick();
      i++;
    end
    if (i == 8) begin
      chk({8'h00, phase_clocks}, 12'h008, "phase");
      end_sim();
    end
    op_code = c;
    op_addr = a;
    op_mem_addr = m;
    op_bit = b;
    op_wdata = d;
    tick();
    op_code = OP_NEXT;
  endtask : op

  task automatic nop();
    op(OP_NEXT, 12'h000, 8'h00, 3'h0, 8'h00);
  endtask : nop

  task automatic pcis(input logic [11:0] e);
    tick();
    chk(pc_out, e, "pc");
  endtask : pcis

  task automatic step(input logic [11:0] e);
    nop();
    pcis(e);
  endtask : step

  task automatic wr(input logic [7:0] m, input logic [7:0] d);
    op(OP_WRITE, 12'h000, m, 3'h0, d);
  endtask : wr

  task automatic rd(input logic [7:0] m, input logic [7:0] e);
    op(OP_NEXT, 12'h000, m, 3'h0, 8'h00);
    tick();
    tick();
    chk({4'h0, read_data}, {4'h0, e}, "read");
  endtask : rd

  task automatic wait_pc(input logic [11:0] e);
    int i;
    i = 0;
    while (pc_out !== e && i < 64) begin
      tick();
      i++;
    end
    chk(pc_out, e, "vector");
    if (i == 64) end_sim();
  endtask : wait_pc

  task automatic t_flow();
    chk({8'h00, phase_clocks}, 12'h001, "phase");
    chk(pc_out, 12'h000, "reset pc");
    step(12'h001);
    op(OP_JUMP, 12'h123, 8'h00, 3'h0, 8'h00);
    pcis(12'h123);
    step(12'h124);
    skip_true = 1'b1;
    op(OP_SKIP, 12'h000, 8'h00, 3'h0, 8'h00);
    skip_true = 1'b0;
    step(12'h126);
    wr(8'h06, 8'h40);
    pcis(12'h140);
    step(12'h141);
  endtask : t_flow

  task automatic t_table();
    wr(8'h07, 8'hC3);
    op(OP_TBL_CUR, 12'h000, 8'h30, 3'h0, 8'h00);
    op(OP_JUMP, 12'h200, 8'h00, 3'h0, 8'h00);
    tick();
    chk({8'h00, pc_out[11:8]}, 12'h001, "page");
    rd(8'h08, 8'h51);
    rd(8'h07, 8'hC3);
    op(OP_TBL_LAST, 12'h000, 8'h31, 3'h0, 8'h00);
    nop();
    wr(8'h08, 8'hAA);
    rd(8'h08, 8'h5F);
    chk({4'h0, mem.ram[8'h30]}, 12'h0C3, "table low");
    chk({4'h0, mem.ram[8'h31]}, 12'h0C3, "table low");
  endtask : t_table

  task automatic t_data();
    wr(8'h01, 8'h32);
    rd(8'h01, 8'hB2);
    wr(8'h00, 8'h0F);
    op(OP_BIT_SET, 12'h000, 8'h00, 3'h7, 8'h00);
    op(OP_BIT_CLR, 12'h000, 8'h32, 3'h0, 8'h00);
    nop();
    nop();
    chk({4'h0, mem.ram[8'h32]}, 12'h08E, "bits");
    rd(8'h2E, 8'h00);
  endtask : t_data

  task automatic t_irq();
    srate_ovf = 1'b1;
    timer_ovf = 1'b1;
    tick();
    srate_ovf = 1'b0;
    timer_ovf = 1'b0;
    tick();
    tick();
    chk({9'h000, irq_flags}, 12'h006, "flags");
    master_irq_enable_set = 1'b1;
    tick();
    master_irq_enable_set = 1'b0;
    wait_pc(12'h008);
    chk({9'h000, irq_flags, master_irq_enable}, 12'h008, "ack");
    nop();
    op(OP_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 3'h0, 8'h00);
    wait_pc(12'h00C);
    nop();
    op(OP_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 3'h0, 8'h00);
    ext_irq_n = 1'b0;
    repeat (4) tick();
    ext_irq_n = 1'b1;
    wait_pc(12'h004);
    nop();
    op(OP_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 3'h0, 8'h00);
    nop();
  endtask : t_irq

  task automatic t_stack();
    for (int k = 0; k < 4; k++) begin
      op(OP_CALL, 12'h300 + 12'(k * 16), 8'h00, 3'h0, 8'h00);
      step(12'h301 + 12'(k * 16));
    end
    ext_irq_n = 1'b0;
    step(12'h332);
    ext_irq_n = 1'b1;
    step(12'h333);
    chk({9'h000, irq_flags}, 12'h001, "held");
    op(OP_RET, 12'h000, 8'h00, 3'h0, 8'h00);
    pcis(12'h321);
    wait_pc(12'h004);
    nop();
    op(OP_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 3'h0, 8'h00);
    pcis(12'h322);
  endtask : t_stack

  initial begin
    nrst = 1'b0;
    op_code = OP_NEXT;
    op_addr = 12'h000;
    op_mem_addr = 8'h00;
    op_bit = 3'h0;
    op_wdata = 8'h00;
    skip_true = 1'b0;
    ext_irq_n = 1'b1;
    srate_ovf = 1'b0;
    timer_ovf = 1'b0;
    irq_enable = 3'h7;
    master_irq_enable_set = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_flow();
    t_table();
    t_data();
    t_irq();
    t_stack();
    end_sim();
  end
endmodule : tb
